// File: design/cfb_pkg.sv
package cfb_pkg;
   // Register byte offsets
   localparam logic [7:0] CFB_OPERAND_OFS = 8'h00;
   localparam logic [7:0] CFB_COMMAND_OFS = 8'h04;
   localparam logic [7:0] CFB_RESULT_OFS = 8'h08;
   localparam logic [7:0] CFB_CONDREG_OFS = 8'h0C;
   localparam logic [7:0] CFB_STATUS_OFS = 8'h10;
   localparam logic [7:0] CFB_PC_OFS = 8'h14;

   // Command word fields
   localparam int CFB_OP_LSB = 0;
   localparam int CFB_RD_LSB = 4;
   localparam int CFB_RA_LSB = 7;
   localparam int CFB_RB_LSB = 10;
   localparam int CFB_CRF_LSB = 13;
   localparam int CFB_BI_LSB = 16;
   localparam int CFB_BJ_LSB = 21;
   localparam int CFB_BD_LSB = 26;
   localparam int CFB_SENSE_BIT = 31;

   // Bit order inside one condition field
   localparam logic [1:0] CFB_LT_POS = 2'h0;
   localparam logic [1:0] CFB_GT_POS = 2'h1;
   localparam logic [1:0] CFB_EQ_POS = 2'h2;
   localparam logic [1:0] CFB_SO_POS = 2'h3;

   // Status register bits
   localparam int CFB_ST_CARRY = 0;
   localparam int CFB_ST_SO = 1;
   localparam int CFB_ST_BR_TAKEN = 2;
   localparam int CFB_ST_BR_VALID = 3;
   localparam int CFB_ST_FLUSH_LSB = 8;

   // Cycles before a compare bit may be consumed
   localparam logic [1:0] CFB_EQ_WAIT = 2'h1;
   localparam logic [1:0] CFB_REST_WAIT = 2'h2;

   localparam logic [31:0] CFB_PC_RESET = 32'h0;
   localparam logic [31:0] CFB_PC_STEP = 32'h4;
   localparam logic [31:0] CFB_CR_RESET = 32'h0;
   localparam logic [2:0] CFB_ZERO_REG = 3'h0;

   typedef enum logic [3:0] {
      CFB_OP_LOADI,
      CFB_OP_CMP,
      CFB_OP_CROR,
      CFB_OP_CRAND,
      CFB_OP_ISEL,
      CFB_OP_ADDC,
      CFB_OP_ADDE,
      CFB_OP_ADDO,
      CFB_OP_BR
   } cfb_op_t;
endpackage

// File: design/cfb_core.sv
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module cfb_core
   import cfb_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp
);
   function automatic logic [4:0] cfb_cr_idx(input logic [2:0] fld, input logic [1:0] pos);
      return {fld, pos};
   endfunction

   logic dp_valid_reg;
   logic dp_write_reg;
   logic [7:0] dp_addr_reg;
   logic hreadyout_reg;
   logic [31:0] hrdata_reg;
   logic hresp_reg;
   logic [31:0] operand_reg;
   logic [31:0] command_reg;
   logic [31:0] result_reg;
   logic [31:0] cr_reg;
   logic [1:0] wait_reg [0:31];
   logic [31:0] gpr_mem [0:7];
   logic carry_reg;
   logic so_reg;
   logic br_taken_reg;
   logic br_valid_reg;
   logic flush_reg;
   logic [7:0] flush_cnt_reg;
   logic [31:0] pc_reg;
   logic [31:0] restart_pc_reg;

   wire logic addr_phase = hsel & htrans[1] & hready;
   wire logic cmd_dp = dp_valid_reg & dp_write_reg & (dp_addr_reg == CFB_COMMAND_OFS) & ~hreadyout_reg;
   wire logic operand_wr = dp_valid_reg & dp_write_reg & (dp_addr_reg == CFB_OPERAND_OFS);

   wire cfb_op_t op = cfb_op_t'(hwdata[CFB_OP_LSB +: 4]);
   wire logic [2:0] rd = hwdata[CFB_RD_LSB +: 3];
   wire logic [2:0] ra = hwdata[CFB_RA_LSB +: 3];
   wire logic [2:0] rb = hwdata[CFB_RB_LSB +: 3];
   wire logic [2:0] crf = hwdata[CFB_CRF_LSB +: 3];
   wire logic [4:0] bi = hwdata[CFB_BI_LSB +: 5];
   wire logic [4:0] bj = hwdata[CFB_BJ_LSB +: 5];
   wire logic [4:0] bd = hwdata[CFB_BD_LSB +: 5];
   wire logic sense = hwdata[CFB_SENSE_BIT];

   wire logic [31:0] a_val = gpr_mem[ra];
   wire logic [31:0] b_val = gpr_mem[rb];
   wire logic bi_val = cr_reg[bi];
   wire logic bj_val = cr_reg[bj];
   wire logic bi_busy = wait_reg[bi] != 2'h0;
   wire logic bj_busy = wait_reg[bj] != 2'h0;

   // Only the bits an op reads can hold it back
   wire logic cr_stall = ((op == CFB_OP_ISEL) & bi_busy)
      | ((op == CFB_OP_BR) & bi_busy)
      | (((op == CFB_OP_CROR) | (op == CFB_OP_CRAND)) & (bi_busy | bj_busy));
   wire logic issue = cmd_dp & ~cr_stall & ~flush_reg;

   wire logic is_add = (op == CFB_OP_ADDC) | (op == CFB_OP_ADDE) | (op == CFB_OP_ADDO);
   wire logic carry_in = (op == CFB_OP_ADDE) & carry_reg;
   wire logic [32:0] add_w = {1'b0, a_val} + {1'b0, b_val} + {32'h0, carry_in};
   wire logic ovf = (a_val[31] == b_val[31]) & (add_w[31] != a_val[31]);
   wire logic so_change = issue & (op == CFB_OP_ADDO) & ovf & ~so_reg;
   wire logic [31:0] isel_first = (ra == CFB_ZERO_REG) ? 32'h0 : a_val;
   wire logic [31:0] isel_w = bi_val ? isel_first : b_val;

   wire logic lt_w = $signed(a_val) < $signed(b_val);
   wire logic gt_w = $signed(a_val) > $signed(b_val);
   wire logic eq_w = a_val == b_val;
   wire logic [3:0] cmp_field = {so_reg, eq_w, gt_w, lt_w};
   wire logic crlog_w = (op == CFB_OP_CROR) ? (bi_val | bj_val) : (bi_val & bj_val);

   wire logic gpr_wr = issue & ((op == CFB_OP_LOADI) | (op == CFB_OP_ISEL) | is_add);
   wire logic [31:0] gpr_data = (op == CFB_OP_LOADI) ? operand_reg : (op == CFB_OP_ISEL) ? isel_w : add_w[31:0];

   wire logic [31:0] status_w = (32'(carry_reg) << CFB_ST_CARRY) | (32'(so_reg) << CFB_ST_SO)
      | (32'(br_taken_reg) << CFB_ST_BR_TAKEN) | (32'(br_valid_reg) << CFB_ST_BR_VALID)
      | (32'(flush_cnt_reg) << CFB_ST_FLUSH_LSB);
   wire logic [7:0] rd_ofs = haddr[7:0];
   wire logic [31:0] rdata_w = (rd_ofs == CFB_OPERAND_OFS) ? operand_reg
      : (rd_ofs == CFB_COMMAND_OFS) ? command_reg
      : (rd_ofs == CFB_RESULT_OFS) ? result_reg
      : (rd_ofs == CFB_CONDREG_OFS) ? cr_reg
      : (rd_ofs == CFB_STATUS_OFS) ? status_w
      : (rd_ofs == CFB_PC_OFS) ? pc_reg : 32'h0;

   assign hrdata = hrdata_reg;
   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;

   // Bus slave: command writes hold the data phase until the op issues
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dp_valid_reg <= 1'b0;
         dp_write_reg <= 1'b0;
         dp_addr_reg <= 8'h00;
         hreadyout_reg <= 1'b1;
         hrdata_reg <= 32'h0;
         hresp_reg <= 1'b0;
      end
      else
      begin
         hresp_reg <= 1'b0;
         if (hready)
         begin
            dp_valid_reg <= addr_phase;
            dp_write_reg <= hwrite;
            dp_addr_reg <= haddr[7:0];
         end
         if (addr_phase & hwrite & (haddr[7:0] == CFB_COMMAND_OFS))
            hreadyout_reg <= 1'b0;
         else if (issue)
            hreadyout_reg <= 1'b1;
         if (addr_phase & ~hwrite)
            hrdata_reg <= rdata_w;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         operand_reg <= 32'h0;
         command_reg <= 32'h0;
         result_reg <= 32'h0;
      end
      else
      begin
         if (operand_wr)
            operand_reg <= hwdata;
         if (issue)
            command_reg <= hwdata;
         if (gpr_wr)
            result_reg <= gpr_data;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < 8; i++)
            gpr_mem[i] <= 32'h0;
      end
      else if (gpr_wr)
         gpr_mem[rd] <= gpr_data;
   end

   // Per-bit readiness: match bit ready a cycle ahead of the others
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         for (int i = 0; i < 32; i++)
            wait_reg[i] <= 2'h0;
      end
      else
      begin
         for (int i = 0; i < 32; i++)
         begin
            if (wait_reg[i] != 2'h0)
               wait_reg[i] <= wait_reg[i] - 2'h1;
         end
         if (issue & (op == CFB_OP_CMP))
         begin
            wait_reg[cfb_cr_idx(crf, CFB_EQ_POS)] <= CFB_EQ_WAIT;
            wait_reg[cfb_cr_idx(crf, CFB_LT_POS)] <= CFB_REST_WAIT;
            wait_reg[cfb_cr_idx(crf, CFB_GT_POS)] <= CFB_REST_WAIT;
            wait_reg[cfb_cr_idx(crf, CFB_SO_POS)] <= CFB_REST_WAIT;
         end
         else if (issue & ((op == CFB_OP_CROR) | (op == CFB_OP_CRAND)))
            wait_reg[bd] <= 2'h0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         cr_reg <= CFB_CR_RESET;
      else if (issue & (op == CFB_OP_CMP))
         cr_reg[{crf, 2'b00} +: 4] <= cmp_field;
      else if (issue & ((op == CFB_OP_CROR) | (op == CFB_OP_CRAND)))
         cr_reg[bd] <= crlog_w;
   end

   // Flags, branch outcome, flush and restart
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         carry_reg <= 1'b0;
         so_reg <= 1'b0;
         br_taken_reg <= 1'b0;
         br_valid_reg <= 1'b0;
         flush_reg <= 1'b0;
         flush_cnt_reg <= 8'h00;
         pc_reg <= CFB_PC_RESET;
         restart_pc_reg <= CFB_PC_RESET;
      end
      else
      begin
         flush_reg <= so_change;
         if (issue & is_add)
            carry_reg <= add_w[32];
         if (issue & (op == CFB_OP_ADDO) & ovf)
            so_reg <= 1'b1;
         if (issue & (op == CFB_OP_BR))
         begin
            br_taken_reg <= bi_val == sense;
            br_valid_reg <= 1'b1;
         end
         if (so_change)
         begin
            flush_cnt_reg <= flush_cnt_reg + 8'h01;
            restart_pc_reg <= pc_reg + CFB_PC_STEP;
         end
         if (flush_reg)
            pc_reg <= restart_pc_reg;
         else if (issue)
            pc_reg <= pc_reg + CFB_PC_STEP;
      end
   end
endmodule

// File: verif/cfb_core_props.sv
`timescale 1ns/1ps
module cfb_core_props
   import cfb_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp
);
   wire tk = hsel && htrans[1] && hready;
   wire cmd = tk && hwrite && haddr[7:0] == CFB_COMMAND_OFS;
   wire rd = tk && !hwrite;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_cmd_stall: assert property (cmd |=> !hreadyout)
      else $error("command did not stall");
   a_cmd_bound: assert property (cmd |=> !hreadyout ##[1:4] hreadyout)
      else $error("command stall too long");
   a_plain_nowait: assert property (tk && !cmd |=> hreadyout)
      else $error("plain access waited");
   a_stall_cause: assert property ($fell(hreadyout) |-> $past(cmd))
      else $error("stall without command");
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("response not okay");
   a_unmapped_zero: assert property (rd && haddr[7:0] > CFB_PC_OFS |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_rdata_hold: assert property (!rd |=> $stable(hrdata))
      else $error("read data moved");
   a_pc_aligned: assert property (rd && haddr[7:0] == CFB_PC_OFS |=> hrdata[1:0] == 2'h0)
      else $error("pc not word aligned");
endmodule
bind cfb_core cfb_core_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));

// File: verif/tb_cfb_core.sv
`timescale 1ns/1ps
module tb_cfb_core;
   import cfb_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] d; logic [7:0] r; logic [31:0] e; int w;} cfb_row_t;
   localparam logic [7:0] OP = CFB_OPERAND_OFS, CM = CFB_COMMAND_OFS, RS = CFB_RESULT_OFS;
   localparam logic [7:0] CD = CFB_CONDREG_OFS, ST = CFB_STATUS_OFS, PC = CFB_PC_OFS;
   localparam logic [31:0] SN = 32'h80000000;
   logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, g, p;
   logic [1:0] htrans = 2'h0;
   logic [7:0] rz [4] = '{RS, CD, ST, PC};
   int n_mismatch = 0, total_checks = 0, cyc = 0, n;
   cfb_row_t rows[$];
   assign hready = hreadyout;
   cfb_core DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp));
   initial forever #5 hclk = ~hclk;
   function automatic logic [31:0] c(input int o, d, a, b, f, i, j, k);
      return 32'(o) | 32'(d) << CFB_RD_LSB | 32'(a) << CFB_RA_LSB | 32'(b) << CFB_RB_LSB
         | 32'(f) << CFB_CRF_LSB | 32'(i) << CFB_BI_LSB | 32'(j) << CFB_BJ_LSB | 32'(k) << CFB_BD_LSB;
   endfunction
   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] v);
      total_checks++;
      if (v !== e)
      begin
         n_mismatch++;
         $display("unexpected %s expected %h seen %h", s, e, v);
      end
   endtask
   // One single AHB transfer; k counts data-phase wait states
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output int k);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, a};
      @(posedge hclk);
      while (hready !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      k = 0;
      @(posedge hclk);
      while (hready !== 1'b1)
      begin
         k++;
         @(posedge hclk);
      end
      r = hrdata;
   endtask
   always @(posedge hclk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         close_out();
      end
   end
   initial
   begin
      rows.push_back('{OP, 32'h5, OP, 32'h5, 0});
      rows.push_back('{CM, c(CFB_OP_LOADI, 1, 0, 0, 0, 0, 0, 0), RS, 32'h5, 1});
      rows.push_back('{OP, 32'h7, OP, 32'h7, 0});
      rows.push_back('{CM, c(CFB_OP_LOADI, 2, 0, 0, 0, 0, 0, 0), RS, 32'h7, 1});
      rows.push_back('{CM, c(CFB_OP_CMP, 0, 1, 2, 0, 0, 0, 0), CD, 32'h1, 1});
      rows.push_back('{CM, c(CFB_OP_CMP, 0, 2, 1, 1, 0, 0, 0), CD, 32'h21, 1});
      rows.push_back('{CM, c(CFB_OP_CMP, 0, 1, 1, 2, 0, 0, 0), CD, 32'h421, 1});
      rows.push_back('{CM, c(CFB_OP_BR, 0, 0, 0, 0, 10, 0, 0) | SN, ST, 32'hC, 1});
      rows.push_back('{CM, c(CFB_OP_CROR, 0, 0, 0, 0, 0, 5, 3), CD, 32'h429, 1});
      rows.push_back('{CM, c(CFB_OP_CRAND, 0, 0, 0, 0, 0, 10, 4), CD, 32'h439, 1});
      rows.push_back('{CM, c(CFB_OP_CMP, 0, 2, 1, 3, 0, 0, 0), CD, 32'h2439, 1});
      rows.push_back('{CM, c(CFB_OP_ISEL, 3, 1, 2, 0, 13, 0, 0), RS, 32'h5, 1});
      rows.push_back('{CM, c(CFB_OP_ISEL, 3, 0, 2, 0, 13, 0, 0), RS, 32'h0, 1});
      rows.push_back('{CM, c(CFB_OP_ISEL, 3, 1, 2, 0, 12, 0, 0), RS, 32'h7, 1});
      rows.push_back('{CM, c(CFB_OP_BR, 0, 0, 0, 0, 12, 0, 0) | SN, ST, 32'h8, 1});
      rows.push_back('{OP, 32'hFFFFFFFF, OP, 32'hFFFFFFFF, 0});
      rows.push_back('{CM, c(CFB_OP_LOADI, 4, 0, 0, 0, 0, 0, 0), RS, 32'hFFFFFFFF, 1});
      rows.push_back('{CM, c(CFB_OP_ADDC, 5, 4, 1, 0, 0, 0, 0), RS, 32'h4, 1});
      rows.push_back('{RS, 32'h55, ST, 32'h9, 0});
      rows.push_back('{CM, c(CFB_OP_ADDE, 6, 1, 2, 0, 0, 0, 0), RS, 32'hD, 1});
      rows.push_back('{OP, 32'h7FFFFFFF, OP, 32'h7FFFFFFF, 0});
      rows.push_back('{CM, c(CFB_OP_LOADI, 7, 0, 0, 0, 0, 0, 0), RS, 32'h7FFFFFFF, 1});
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[i])
      begin
         xfer(1'b1, rows[i].a, rows[i].d, g, n);
         chk("wait states", 32'(rows[i].w), 32'(n));
         xfer(1'b0, rows[i].r, 32'h0, g, n);
         chk("readback", rows[i].e, g);
      end
      xfer(1'b1, 8'h40, 32'hA5A5A5A5, g, n);
      xfer(1'b0, 8'h40, 32'h0, g, n);
      chk("unmapped read", 32'h0, g);
      // First overflow sets the sticky flag and flushes, the second does not flush again or bump the flush count
      for (int i = 0; i < 2; i++)
      begin
         xfer(1'b0, PC, 32'h0, p, n);
         xfer(1'b1, CM, c(CFB_OP_ADDO, 5, 7, 7, 0, 0, 0, 0), g, n);
         chk("overflow waits", 32'h1, 32'(n));
         xfer(1'b0, PC, 32'h0, g, n);
         chk("restart address", p + CFB_PC_STEP, g);
         xfer(1'b0, ST, 32'h0, g, n);
         chk("flush status", 32'h102, g & 32'hFF02);
      end
      // A compare now copies the sticky overflow into its field
      xfer(1'b1, CM, c(CFB_OP_CMP, 0, 1, 2, 7, 0, 0, 0), g, n);
      xfer(1'b0, CD, 32'h0, g, n);
      chk("sticky overflow in compare", 32'h90002439, g);
      // An undefined op completes and leaves the result alone
      xfer(1'b1, CM, c(4'hF, 1, 0, 0, 0, 0, 0, 0), g, n);
      xfer(1'b0, RS, 32'h0, g, n);
      chk("illegal op result", 32'hFFFFFFFE, g);
      hresetn <= 1'b0;
      repeat (3) @(posedge hclk);
      chk("reset hreadyout", 32'h1, 32'(hreadyout));
      chk("reset hrdata", 32'h0, hrdata);
      chk("reset hresp", 32'h0, 32'(hresp));
      hresetn <= 1'b1;
      foreach (rz[i])
      begin
         xfer(1'b0, rz[i], 32'h0, g, n);
         chk("reset value", 32'h0, g);
      end
      close_out();
   end
endmodule
